// File: logic/async_serial_receiver.sv
// Asynchronous serial receiver with two-entry FIFO and AHB-Lite register slave
//
// The implementer's own choices: register access over AHB-Lite and the register addresses.
`timescale 1ns/1ns

////////////////////////////////////////////////////////////////////////////////
// How it works
// - Oversample the line at sixteen ticks per bit; shift register advances per bit.
// - Completed 8 or 9 bit character moves at once into two-entry FIFO.
// - Shift register and FIFO entries are hidden; only data port pops characters.
// - Receive only with receive_enable 1, clocked mode 0, serial_port_enable 1.
// - A falling edge of the line starts a character; start bit is low.
// - Half a bit after the edge, check the start bit is still low.
// - High start bit at mid-bit aborts silently, no error, hunt again.
// - Each later bit centre a full bit on, majority voted, shifted in.
// - Stop position sampled one bit later; low sets framing error, high clears.
// - Right after stop, push character and raise character-available flag.
// - Reading the data port returns the oldest character and removes it.
// - While overrun pends, no further characters enter the FIFO.
// - First bit after start becomes data bit zero.
// - nine_bit_receive_sel picks nine data bits, else eight.
// - Third character with FIFO full sets overrun, or is lost with no overrun if a data-port pop falls in the same cycle; cleared by either enable.
// - Framing error stored per entry; framing_flag shows the oldest.
module async_serial_receiver
  import rx_serial_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic receive_data_pin,
  output logic rx_char_available_flag
);

  typedef enum logic [1:0] {ST_IDLE, ST_START, ST_DATA, ST_STOP} rx_state_e;

  function automatic logic maj3(input logic [2:0] v);
    maj3 = (v[0] & v[1]) | (v[0] & v[2]) | (v[1] & v[2]);
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Registers and bus state
  logic [7:0] rx_ctrl_q;
  logic [7:0] tx_ctrl_q;
  logic [7:0] baud_ctrl_q;
  logic [7:0] div_lo_q;
  logic [7:0] div_hi_q;
  logic wr_ph_q;
  logic rd_ph_q;
  logic [ADDR_W-1:0] addr_q;
  logic take;
  logic pop;
  logic serial_port_enable;
  logic receive_enable;
  logic rx_on;

  // Receiver state
  rx_state_e state_q;
  logic [CNT_W-1:0] cnt_q;
  logic [3:0] bit_cnt_q;
  logic [DATA_W-1:0] shreg_q;
  logic [1:0] votes_q;
  logic [15:0] div_cnt_q;
  logic tick;
  logic sync1_q;
  logic sync2_q;
  logic rx_prev_q;
  logic vote;
  logic in_vote;
  logic push;
  logic framing_flag_new;
  logic [DATA_W-1:0] char_done;

  // FIFO
  logic [DATA_W:0] mem_q [DEPTH];
  logic [$clog2(DEPTH)-1:0] wr_ptr_q;
  logic [$clog2(DEPTH)-1:0] rd_ptr_q;
  logic [$clog2(DEPTH):0] count_q;
  logic overrun_flag_q;
  logic [DATA_W:0] top;
  logic fifo_full;

  assign serial_port_enable = rx_ctrl_q[BIT_SERIAL_PORT_ENABLE];
  assign receive_enable = rx_ctrl_q[BIT_RECEIVE_ENABLE];
  assign rx_on = receive_enable & ~tx_ctrl_q[BIT_SYNC] & serial_port_enable;
  assign top = mem_q[rd_ptr_q];
  assign fifo_full = (count_q == ($clog2(DEPTH)+1)'(DEPTH));
  assign rx_char_available_flag = (count_q != '0);

  //////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave: writes zero wait, reads one wait state
  assign take = hsel & htrans[1] & hready;
  assign hreadyout = ~rd_ph_q;
  assign hresp = 1'b0;
  assign pop = rd_ph_q & (addr_q == OFS_RX_DATA_PORT) & (count_q != '0);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ph_q <= 1'b0;
      rd_ph_q <= 1'b0;
      addr_q <= '0;
    end else begin
      wr_ph_q <= take & hwrite;
      rd_ph_q <= take & ~hwrite;
      if (take) begin
        addr_q <= haddr[ADDR_W-1:0];
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_ctrl_q <= RST_RX_STAT_CTRL;
      tx_ctrl_q <= RST_TX_STAT_CTRL;
      baud_ctrl_q <= RST_BAUD_CTRL;
      div_lo_q <= RST_BAUD_DIV;
      div_hi_q <= RST_BAUD_DIV;
    end else if (wr_ph_q) begin
      unique case (addr_q)
        OFS_RX_STAT_CTRL: rx_ctrl_q <= hwdata[7:0];
        OFS_TX_STAT_CTRL: tx_ctrl_q <= hwdata[7:0];
        OFS_BAUD_CTRL: baud_ctrl_q <= hwdata[7:0];
        OFS_BAUD_DIV_LO: div_lo_q <= hwdata[7:0];
        OFS_BAUD_DIV_HI: div_hi_q <= hwdata[7:0];
        default: ;
      endcase
    end
  end

  // Read data; the shift register and FIFO entries have no address
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= '0;
    end else if (rd_ph_q) begin
      hrdata <= '0;
      unique case (addr_q)
        OFS_RX_STAT_CTRL: begin
          hrdata[7:0] <= rx_ctrl_q;
          hrdata[BIT_FRAMING_FLAG] <= (count_q != '0) & top[DATA_W];
          hrdata[BIT_OVERRUN_FLAG] <= overrun_flag_q;
          hrdata[BIT_RX9D] <= (count_q != '0) & top[DATA_W-1];
        end
        OFS_TX_STAT_CTRL: hrdata[7:0] <= tx_ctrl_q;
        OFS_BAUD_CTRL: begin
          hrdata[7:0] <= baud_ctrl_q;
          hrdata[BIT_RCIDL] <= (state_q == ST_IDLE);
        end
        OFS_BAUD_DIV_LO: hrdata[7:0] <= div_lo_q;
        OFS_BAUD_DIV_HI: hrdata[7:0] <= div_hi_q;
        OFS_RX_DATA_PORT: hrdata[7:0] <= top[7:0];
        OFS_PERIPH_FLAGS: hrdata[BIT_RX_CHAR_AVAILABLE_FLAG] <= rx_char_available_flag;
        default: ;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Sixteen-per-bit tick from the baud divisor
  assign tick = rx_on & (div_cnt_q == '0);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_cnt_q <= '0;
    end else if (!rx_on || div_cnt_q == '0) begin
      div_cnt_q <= {div_hi_q, div_lo_q};
    end else begin
      div_cnt_q <= div_cnt_q - 16'h0001;
    end
  end

  // Line synchroniser and edge history
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sync1_q <= 1'b1;
      sync2_q <= 1'b1;
      rx_prev_q <= 1'b1;
    end else begin
      sync1_q <= receive_data_pin;
      sync2_q <= sync1_q;
      rx_prev_q <= sync2_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Receive state machine
  assign in_vote = (cnt_q >= VOTE_FIRST) && (cnt_q <= VOTE_LAST);
  assign vote = maj3({votes_q, sync2_q});
  assign char_done = rx_ctrl_q[BIT_RX9] ? shreg_q : {1'b0, shreg_q[DATA_W-1:1]};
  assign framing_flag_new = ~vote;
  assign push = tick & (state_q == ST_STOP) & (cnt_q == VOTE_LAST);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= ST_IDLE;
      cnt_q <= '0;
      bit_cnt_q <= '0;
      shreg_q <= '0;
      votes_q <= '0;
    end else if (!rx_on) begin
      state_q <= ST_IDLE;
      cnt_q <= '0;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          cnt_q <= '0;
          if (rx_prev_q && !sync2_q) begin
            state_q <= ST_START;
          end
        end
        default: begin
          if (tick) begin
            cnt_q <= cnt_q + 4'h1;
            if (in_vote) begin
              votes_q <= {votes_q[0], sync2_q};
            end
            if (cnt_q == VOTE_LAST) begin
              unique case (state_q)
                ST_START: begin
                  bit_cnt_q <= '0;
                  state_q <= vote ? ST_IDLE : ST_DATA;
                end
                ST_DATA: begin
                  shreg_q <= {vote, shreg_q[DATA_W-1:1]};
                  bit_cnt_q <= bit_cnt_q + 4'h1;
                  if (bit_cnt_q + 4'h1 ==
                      (rx_ctrl_q[BIT_RX9] ? BITS_NINE : BITS_EIGHT)) begin
                    state_q <= ST_STOP;
                  end
                end
                default: state_q <= ST_IDLE;
              endcase
            end
          end
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Two-entry FIFO with framing status per entry and overrun
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
    end else if (!serial_port_enable) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
    end else begin
      if (push && !overrun_flag_q && !fifo_full) begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= rd_ptr_q + 1'b1;
      end
      if ((push && !overrun_flag_q && !fifo_full) && !pop) begin
        count_q <= count_q + 1'b1;
      end else if (!(push && !overrun_flag_q && !fifo_full) && pop) begin
        count_q <= count_q - 1'b1;
      end
    end
  end

  always_ff @(posedge hclk) begin
    if (push && serial_port_enable && !overrun_flag_q && !fifo_full) begin
      mem_q[wr_ptr_q] <= {framing_flag_new, char_done};
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      overrun_flag_q <= 1'b0;
    end else if (!receive_enable || !serial_port_enable) begin
      overrun_flag_q <= 1'b0;
    end else if (push && fifo_full && !pop) begin
      overrun_flag_q <= 1'b1;
    end
  end

endmodule

// File: logic/rx_serial_pkg.sv
// Constants shared by the asynchronous serial receiver
package rx_serial_pkg;
  // Register byte offsets on the AHB-Lite bus
  localparam logic [7:0] OFS_RX_STAT_CTRL = 8'h00;
  localparam logic [7:0] OFS_TX_STAT_CTRL = 8'h04;
  localparam logic [7:0] OFS_BAUD_CTRL = 8'h08;
  localparam logic [7:0] OFS_BAUD_DIV_LO = 8'h0C;
  localparam logic [7:0] OFS_BAUD_DIV_HI = 8'h10;
  localparam logic [7:0] OFS_RX_DATA_PORT = 8'h14;
  localparam logic [7:0] OFS_PERIPH_FLAGS = 8'h18;
  localparam int ADDR_W = 8;
  // receive_status_control fields
  localparam int BIT_SERIAL_PORT_ENABLE = 7;
  localparam int BIT_RX9 = 6;
  localparam int BIT_RECEIVE_ENABLE = 4;
  localparam int BIT_FRAMING_FLAG = 2;
  localparam int BIT_OVERRUN_FLAG = 1;
  localparam int BIT_RX9D = 0;
  // transmit_status_control field
  localparam int BIT_SYNC = 4;
  // baud_control field
  localparam int BIT_RCIDL = 6;
  // peripheral_flag_reg field
  localparam int BIT_RX_CHAR_AVAILABLE_FLAG = 5;
  // Reset values
  localparam logic [7:0] RST_RX_STAT_CTRL = 8'h00;
  localparam logic [7:0] RST_TX_STAT_CTRL = 8'h00;
  localparam logic [7:0] RST_BAUD_CTRL = 8'h00;
  localparam logic [7:0] RST_BAUD_DIV = 8'h00;
  // Oversampling: ticks per bit and the three vote points around the centre
  localparam int OVERSAMPLE = 16;
  localparam int CNT_W = 4;
  localparam logic [3:0] VOTE_FIRST = 4'h7;
  localparam logic [3:0] VOTE_LAST = 4'h9;
  localparam logic [3:0] BITS_EIGHT = 4'h8;
  localparam logic [3:0] BITS_NINE = 4'h9;
  // FIFO depth in characters
  localparam int FIFO_DEPTH = 2;
  localparam int DATA_W = 9;
endpackage

// File: verif/async_serial_receiver_tb_top.sv
// Self-checking bench for the asynchronous serial receiver
`timescale 1ns/1ns
module async_serial_receiver_tb_top import rx_serial_pkg::*;;
  logic hclk;
  logic hresetn;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [31:0] hwdata;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic rx_line;
  logic rx_flag;
  logic [31:0] rd;
  int num_errors;
  int n_compared;
  async_serial_receiver i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .receive_data_pin(rx_line),
    .rx_char_available_flag(rx_flag));
  serial_tx_model #(.BIT_CYC(32)) i_tx (.clk(hclk), .line(rx_line));
  ////////////////////////////////////////////////////////////////////////////////
  // Shared tasks
  task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h000000, a};
    hwrite <= w;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string nm);
    bus(a, 1'b0, 32'h0);
    check(nm, rd, exp);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(a, 1'b1, d);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_regs();
    rdchk(OFS_RX_STAT_CTRL, 32'h0, "status");
    wr(OFS_BAUD_DIV_LO, 32'h01);
    rdchk(OFS_BAUD_DIV_LO, 32'h01, "divisor");
    wr(8'h1C, 32'hFF);
    rdchk(8'h1C, 32'h0, "unmapped");
  endtask
  task automatic t_one();
    wr(OFS_RX_STAT_CTRL, 32'h90);
    i_tx.send(9'h05A, 8, 1'b1);
    rdchk(OFS_PERIPH_FLAGS, 32'h20, "flag reg");
    rdchk(OFS_RX_DATA_PORT, 32'h5A, "data");
    check("flag", {31'h0, rx_flag}, 32'h0);
  endtask
  task automatic t_fifo();
    i_tx.send(9'h011, 8, 1'b1);
    i_tx.send(9'h022, 8, 1'b0);
    i_tx.send(9'h033, 8, 1'b1);
    rdchk(OFS_RX_STAT_CTRL, 32'h92, "overrun");
    rdchk(OFS_RX_DATA_PORT, 32'h11, "first");
    rdchk(OFS_RX_STAT_CTRL, 32'h96, "framing");
    i_tx.send(9'h044, 8, 1'b1);
    rdchk(OFS_RX_DATA_PORT, 32'h22, "second");
    check("held", {31'h0, rx_flag}, 32'h0);
    wr(OFS_RX_STAT_CTRL, 32'h80);
    rdchk(OFS_RX_STAT_CTRL, 32'h80, "cleared");
  endtask
  task automatic t_odd();
    wr(OFS_RX_STAT_CTRL, 32'hD0);
    i_tx.glitch();
    rdchk(OFS_RX_STAT_CTRL, 32'hD0, "abort");
    i_tx.send(9'h1A5, 9, 1'b1);
    rdchk(OFS_RX_STAT_CTRL, 32'hD1, "ninth");
    rdchk(OFS_RX_DATA_PORT, 32'hA5, "nine");
  endtask
  task automatic t_gate();
    wr(OFS_RX_STAT_CTRL, 32'h80);
    i_tx.send(9'h077, 8, 1'b1);
    check("off", {31'h0, rx_flag}, 32'h0);
    wr(OFS_TX_STAT_CTRL, 32'h10);
    wr(OFS_RX_STAT_CTRL, 32'h90);
    i_tx.send(9'h066, 8, 1'b1);
    check("clocked", {31'h0, rx_flag}, 32'h0);
    wr(OFS_TX_STAT_CTRL, 32'h00);
    i_tx.send(9'h055, 8, 1'b1);
    check("on", {31'h0, rx_flag}, 32'h1);
    wr(OFS_RX_STAT_CTRL, 32'h10);
    repeat (2) @(posedge hclk);
    check("flush", {31'h0, rx_flag}, 32'h0);
  endtask
  task automatic wrap_up();
    $display("compared %0d errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Clock, reset, sequence and watchdog
  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    num_errors = 0;
    n_compared = 0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_regs();
    t_one();
    t_fifo();
    t_odd();
    t_gate();
    wrap_up();
  end
  initial begin
    repeat (20000) @(posedge hclk);
    num_errors++;
    wrap_up();
  end
endmodule

// File: verif/rx_serial_assertions.sv
// Port checks for the asynchronous serial receiver
`timescale 1ns/1ns
module rx_serial_checker (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic receive_data_pin,
  input wire logic rx_char_available_flag
);
  logic take;
  logic bus_q;
  logic [9:0] low_age_q;
  assign take = hsel && htrans[1] && hready;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  ////////////////////////////////////////////////////////////////////////////////
  // Bus phase tracker and age of the last low line level
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_q <= 1'b0;
    end else if (hready) begin
      bus_q <= take;
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      low_age_q <= 10'h000;
    end else if (!receive_data_pin) begin
      low_age_q <= 10'h000;
    end else if (low_age_q != 10'h3FF) begin
      low_age_q <= low_age_q + 10'h001;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Assertions
  property p_okay; hresp == 1'b0; endproperty
  a_okay: assert property (p_okay) else $error("hresp not OKAY");
  property p_rd_wait; take && !hwrite |=> !hreadyout ##1 hreadyout; endproperty
  a_rd_wait: assert property (p_rd_wait) else $error("read wait wrong");
  property p_wr_nowait; take && hwrite |=> hreadyout; endproperty
  a_wr_nowait: assert property (p_wr_nowait) else $error("write stalled");
  property p_low_cause; $fell(hreadyout) |-> $past(take && !hwrite); endproperty
  a_low_cause: assert property (p_low_cause) else $error("stall without read");
  property p_low_once; !hreadyout |=> hreadyout; endproperty
  a_low_once: assert property (p_low_once) else $error("stall too long");
  property p_rdata; !$stable(hrdata) |-> $past(!hreadyout); endproperty
  a_rdata: assert property (p_rdata) else $error("hrdata moved");
  property p_flag_fall;
    $fell(rx_char_available_flag) |-> $past(bus_q) || $past(bus_q, 2);
  endproperty
  a_flag_fall: assert property (p_flag_fall) else $error("flag fell alone");
  property p_flag_rise; $rose(rx_char_available_flag) |-> low_age_q < 10'h3E8; endproperty
  a_flag_rise: assert property (p_flag_rise) else $error("flag without frame");
endmodule

bind async_serial_receiver rx_serial_checker i_chk (
  .hclk(hclk),
  .hresetn(hresetn),
  .hsel(hsel),
  .htrans(htrans),
  .hwrite(hwrite),
  .hready(hready),
  .hreadyout(hreadyout),
  .hresp(hresp),
  .hrdata(hrdata),
  .receive_data_pin(receive_data_pin),
  .rx_char_available_flag(rx_char_available_flag)
);

// File: verif/serial_tx_model.sv
// Remote transmitter model driving the serial line
`timescale 1ns/1ns
module serial_tx_model #(
  parameter int BIT_CYC = 32
) (
  input wire logic clk,
  output logic line
);
  // Pin is a plain digital input here
  initial line = 1'b1;
  // Start space, data bits, stop level, one idle bit
  task automatic send(input logic [8:0] d, input int nb, input logic stop);
    line <= 1'b0;
    repeat (BIT_CYC) @(posedge clk);
    for (int i = 0; i < nb; i++) begin
      line <= d[i];
      repeat (BIT_CYC) @(posedge clk);
    end
    line <= stop;
    repeat (BIT_CYC) @(posedge clk);
    line <= 1'b1;
    repeat (BIT_CYC) @(posedge clk);
  endtask
  // Low pulse that is high again before mid-bit
  task automatic glitch();
    line <= 1'b0;
    repeat (BIT_CYC / 8) @(posedge clk);
    line <= 1'b1;
    repeat (2 * BIT_CYC) @(posedge clk);
  endtask
endmodule
